//--- src/timer2_cfg.svh
// timer2_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the timer2 block and the test bench, APB byte addressing
`ifndef TIMER2_CFG_SVH
`define TIMER2_CFG_SVH

// ============================================================
// register byte offsets
`define T2_OFF_CONTROL   12'h000
`define T2_OFF_MODE      12'h004
`define T2_OFF_COUNT     12'h008
`define T2_OFF_RELOAD    12'h00C
`define T2_OFF_STATUS    12'h010

// ============================================================
// control register fields
`define T2_CTL_OVF       7
`define T2_CTL_EXT       6
`define T2_CTL_SSI_HI    5
`define T2_CTL_SSI_LO    4
`define T2_CTL_EXEN      3
`define T2_CTL_RUN       2
`define T2_CTL_CSEL      1
`define T2_CTL_CPRL      0

// mode register fields
`define T2_MOD_PRE_HI    3
`define T2_MOD_PRE_LO    2
`define T2_MOD_CLKOE     1
`define T2_MOD_DOWN_COUNT_ENABLE      0

// ============================================================
// reset values and counts
`define T2_CTL_RESET     8'h00
`define T2_MOD_RESET     8'h00
`define T2_WORD_RESET    16'h0000
`define T2_ALL_ONES      16'hFFFF
`define T2_OSC_PER_STATE 2'h3
`define T2_DATA_ZERO     32'h0000_0000
`define T2_ADDR_W        12

`endif

//--- src/timer2_pkg.sv
// timer2_pkg: types shared by the timer 2 block
// assumes: timer2_cfg.svh holds the numeric constants
package timer2_pkg;

   // ============================================================
   // operating mode of the counter
   typedef enum logic [2:0] {
      MODE_RELOAD,
      MODE_CLKOUT,
      MODE_CAPTURE,
      MODE_STOPPED,
      MODE_BAUD
   } t2_mode_t;

   // pins facing the outside world
   typedef struct packed {
      logic ext_trigger_pin;
      logic count_pin;
   } t2_pins_in_t;

   // baud ticks toward the serial ports, overflow and external event flags
   typedef struct packed {
      logic [2:0] baud_tick;
      logic       overflow_flag;
      logic       ext_event_flag;
   } t2_events_t;

endpackage : timer2_pkg

//--- src/timer2_capture_reload_clockout.sv
// timer2_capture_reload_clockout: 16-bit timer/counter with capture, auto-reload,
// up/down count, clock-out and baud rate generation, reached over APB
// assumes: pins synchronous to pclk, pclk is the oscillator clock
//
// Notes on behaviour
// - capture mode counts 16 bits, wrap sets overflow flag, may interrupt
// - capture mode trigger fall copies count into reload/capture pair
// - that trigger fall sets the external event flag, interrupt capable
// - reset clears down-count enable, so auto-reload counts up
// - up count to FFFF, overflow sets flag and reloads from pair
// - with trigger enabled, trigger fall also reloads and sets event flag
// - up/down with pin high counts up, FFFF overflow sets flag, reloads
// - pin low counts down; equal to pair sets flag, loads FFFF
// - up/down: event flag toggles each wrap, never interrupts
// - clock-out counts preload to overflow, reloads, no interrupt
// - clock-out enable feeds overflows to divide-by-two driving output pin
// - clock-out timer rate is oscillator over three times prescale plus one
// - clock-out and baud run together sharing the reload/capture pair
// - nonzero port select gives baud mode; high byte rollover reloads
// - baud mode: no overflow flag; trigger fall sets event, no reload
// - baud mode advances every 1 to 4 state times by prescale
// - 11.0592 MHz, prescale 0: FFE8 gives 9600, FFFF gives 230400
// - port select 00 none, 01 port0, 10 port1, 11 port2
// - select zero: reload, clock-out, capture, stopped; reload default
`timescale 1ns/1ps
`include "timer2_cfg.svh"

module timer2_capture_reload_clockout
   import timer2_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`T2_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire t2_pins_in_t            pins_in,
   output logic                        clock_output_pin,
   output logic                        clock_output_oe,
   output t2_events_t                  events
);

   // ============================================================
   // registers
   logic [7:0]  ctl_r;
   logic [7:0]  mod_r;
   logic [15:0] count_r;
   logic [15:0] reload_r;
   logic [1:0]  pre_cnt_r;
   logic [1:0]  osc_cnt_r;
   logic        trig_d_r;
   logic        cpin_d_r;
   logic        div2_r;
   logic [2:0]  baud_r;

   // ============================================================
   // field views
   wire       run_bit              = ctl_r[`T2_CTL_RUN];
   wire       ext_trigger_enable   = ctl_r[`T2_CTL_EXEN];
   wire       counter_select       = ctl_r[`T2_CTL_CSEL];
   wire       capture_reload_select = ctl_r[`T2_CTL_CPRL];
   wire [1:0] serial_port_select   = ctl_r[`T2_CTL_SSI_HI:`T2_CTL_SSI_LO];
   wire [1:0] prescale_field       = mod_r[`T2_MOD_PRE_HI:`T2_MOD_PRE_LO];
   wire       clock_out_enable     = mod_r[`T2_MOD_CLKOE];
   wire       down_count_enable    = mod_r[`T2_MOD_DOWN_COUNT_ENABLE];

   // mode decode from select fields
   t2_mode_t  mode;
   assign mode = (serial_port_select != 2'h0) ? MODE_BAUD :
                 ({capture_reload_select, clock_out_enable} == 2'h0) ? MODE_RELOAD :
                 ({capture_reload_select, clock_out_enable} == 2'h1) ? MODE_CLKOUT :
                 ({capture_reload_select, clock_out_enable} == 2'h2) ? MODE_CAPTURE :
                 MODE_STOPPED;

   // ============================================================
   // apb decode
   wire acc     = psel & penable;
   wire wr      = acc & pwrite;
   wire hit_ctl = (paddr == `T2_OFF_CONTROL);
   wire hit_mod = (paddr == `T2_OFF_MODE);
   wire hit_cnt = (paddr == `T2_OFF_COUNT);
   wire hit_rld = (paddr == `T2_OFF_RELOAD);
   wire hit_sta = (paddr == `T2_OFF_STATUS);
   wire mapped  = hit_ctl | hit_mod | hit_cnt | hit_rld | hit_sta;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ============================================================
   // count tick: state time is three oscillator periods
   wire state_tick = (osc_cnt_r == `T2_OSC_PER_STATE - 2'h1);
   wire pre_done   = (pre_cnt_r == prescale_field);
   wire timer_tick = state_tick & pre_done;
   wire count_fall = cpin_d_r & ~pins_in.count_pin;
   wire trig_fall  = trig_d_r & ~pins_in.ext_trigger_pin;
   wire qual_fall  = trig_fall & ext_trigger_enable;
   wire run_ok     = run_bit & (mode != MODE_STOPPED);
   wire tick       = run_ok & (counter_select ? count_fall : timer_tick);

   // up/down direction only in auto-reload with down count enabled
   wire updown     = (mode == MODE_RELOAD) & down_count_enable;
   wire count_down = updown & ~pins_in.ext_trigger_pin;
   wire at_top     = (count_r == `T2_ALL_ONES);
   wire at_floor   = (count_r == reload_r);
   wire wrap_up    = tick & ~count_down & at_top;
   wire wrap_down  = tick & count_down & at_floor;
   wire wrap       = wrap_up | wrap_down;
   wire hi_roll    = tick & (count_r[15:8] == 8'hFF) & (count_r[7:0] == 8'hFF);

   // reload, capture and flag sources
   wire edge_reload = qual_fall & run_bit & (mode == MODE_RELOAD) & ~down_count_enable;
   wire set_ovf    = wrap & (mode != MODE_BAUD) & (mode != MODE_CLKOUT);
   wire set_ext    = qual_fall & ~updown;
   wire toggle_ext = wrap & updown;
   wire capture    = qual_fall & (mode == MODE_CAPTURE);

   // ============================================================
   // next count value
   logic [15:0] count_nxt;
   always_comb begin
      count_nxt = count_r;
      if (wr && hit_cnt) begin
         count_nxt = pwdata[15:0];
      end else if (wrap_down) begin
         count_nxt = `T2_ALL_ONES;
      end else if ((mode == MODE_BAUD) && hi_roll) begin
         count_nxt = reload_r;
      end else if (wrap_up && (mode != MODE_CAPTURE)) begin
         count_nxt = reload_r;
      end else if (edge_reload) begin
         count_nxt = reload_r;
      end else if (tick) begin
         count_nxt = count_down ? count_r - 16'h0001 : count_r + 16'h0001;
      end
   end

   // next control value: hardware set wins over software clear
   logic [7:0] ctl_nxt;
   always_comb begin
      ctl_nxt = (wr && hit_ctl) ? pwdata[7:0] : ctl_r;
      if (set_ovf) begin
         ctl_nxt[`T2_CTL_OVF] = 1'b1;
      end
      if (set_ext) begin
         ctl_nxt[`T2_CTL_EXT] = 1'b1;
      end else if (toggle_ext) begin
         ctl_nxt[`T2_CTL_EXT] = ~ctl_r[`T2_CTL_EXT];
      end
   end

   // ============================================================
   // prescaler and state time counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt_r <= 2'h0;
         pre_cnt_r <= 2'h0;
      end else begin
         osc_cnt_r <= state_tick ? 2'h0 : osc_cnt_r + 2'h1;
         if (state_tick) begin
            pre_cnt_r <= pre_done ? 2'h0 : pre_cnt_r + 2'h1;
         end
      end
   end

   // control, mode and counter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r   <= `T2_CTL_RESET;
         mod_r   <= `T2_MOD_RESET;
         count_r <= `T2_WORD_RESET;
      end else begin
         ctl_r   <= ctl_nxt;
         count_r <= count_nxt;
         if (wr && hit_mod) begin
            mod_r <= pwdata[7:0];
         end
      end
   end

   // reload/capture pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_r <= `T2_WORD_RESET;
      end else if (capture) begin
         reload_r <= count_r;
      end else if (wr && hit_rld) begin
         reload_r <= pwdata[15:0];
      end
   end

   // pin edge history, divide-by-two clock output and baud tick registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_d_r <= 1'b1;
         cpin_d_r <= 1'b1;
         div2_r   <= 1'b0;
         baud_r   <= 3'h0;
      end else begin
         trig_d_r <= pins_in.ext_trigger_pin;
         cpin_d_r <= pins_in.count_pin;
         if (clock_out_enable && wrap_up) begin
            div2_r <= ~div2_r;
         end
         baud_r[0] <= (serial_port_select == 2'h1) & hi_roll;
         baud_r[1] <= (serial_port_select == 2'h2) & hi_roll;
         baud_r[2] <= (serial_port_select == 2'h3) & hi_roll;
      end
   end

   // ============================================================
   // outputs
   assign clock_output_pin      = div2_r;
   assign clock_output_oe       = clock_out_enable & ~counter_select;
   assign events.baud_tick      = baud_r;
   assign events.overflow_flag  = ctl_r[`T2_CTL_OVF];
   assign events.ext_event_flag = ctl_r[`T2_CTL_EXT] & ~down_count_enable;

   // read mux
   wire [7:0] status = {5'h00, mode};
   always_comb begin
      prdata = `T2_DATA_ZERO;
      if (hit_ctl) begin
         prdata = {24'h000000, ctl_r};
      end else if (hit_mod) begin
         prdata = {24'h000000, mod_r};
      end else if (hit_cnt) begin
         prdata = {16'h0000, count_r};
      end else if (hit_rld) begin
         prdata = {16'h0000, reload_r};
      end else if (hit_sta) begin
         prdata = {24'h000000, status};
      end
   end

   // ============================================================
   // checks
   overflow_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      set_ovf |=> ctl_r[`T2_CTL_OVF]) else $error("overflow flag not set");
   capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      capture |=> reload_r == $past(count_r)) else $error("capture missed");
   reload_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap_up && mode == MODE_RELOAD && !(wr && hit_cnt))
      |=> count_r == $past(reload_r)) else $error("reload on wrap missed");
   underflow_top_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap_down && !(wr && hit_cnt)) |=> count_r == `T2_ALL_ONES)
      else $error("underflow load wrong");
   baud_no_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_BAUD && !(wr && hit_ctl)) |=> $stable(ctl_r[`T2_CTL_OVF]) ||
      $past(ctl_r[`T2_CTL_OVF]) == 1'b0 && ctl_r[`T2_CTL_OVF] == 1'b0)
      else $error("flag moved in baud mode");
   event_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (toggle_ext && !set_ext && !(wr && hit_ctl))
      |=> ctl_r[`T2_CTL_EXT] != $past(ctl_r[`T2_CTL_EXT])) else $error("no toggle");
   freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!run_bit && !(wr && hit_cnt)) |=> $stable(count_r)) else $error("count moved");
   divider_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clock_out_enable && wrap_up) |=> clock_output_pin != $past(clock_output_pin))
      else $error("divider missed");

   // ============================================================
   // further checks
   // flag setting, clearing and holding
   ext_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      set_ext |=> ctl_r[`T2_CTL_EXT])
      else $error("event flag not set");
   reload_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      edge_reload |=> ctl_r[`T2_CTL_EXT])
      else $error("reload edge left event flag clear");
   baud_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_BAUD && qual_fall) |=> ctl_r[`T2_CTL_EXT])
      else $error("baud edge left event flag clear");
   updown_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (updown && qual_fall && !wrap && !(wr && hit_ctl)) |=> $stable(ctl_r[`T2_CTL_EXT]))
      else $error("trigger edge moved event flag in up/down");
   up_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap_up && mode == MODE_RELOAD) |=> ctl_r[`T2_CTL_OVF])
      else $error("reload overflow left flag clear");
   underflow_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_down |=> ctl_r[`T2_CTL_OVF])
      else $error("underflow left flag clear");
   clkout_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_CLKOUT && !(wr && hit_ctl)) |=> $stable(ctl_r[`T2_CTL_OVF]))
      else $error("flag moved in clock-out mode");
   ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_ctl && !pwdata[`T2_CTL_OVF] && !set_ovf) |=> !ctl_r[`T2_CTL_OVF])
      else $error("software clear of overflow flag lost");

   // count register paths
   capture_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_CAPTURE && tick && !(wr && hit_cnt)) |=> count_r == $past(count_r) + 16'h0001)
      else $error("capture mode count step wrong");
   capture_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture && !tick && !(wr && hit_cnt)) |=> $stable(count_r))
      else $error("capture disturbed the count");
   edge_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (edge_reload && !(wr && hit_cnt)) |=> count_r == $past(reload_r))
      else $error("reload on trigger edge missed");
   up_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (updown && pins_in.ext_trigger_pin && tick && !at_top && !(wr && hit_cnt))
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("up count step wrong");
   down_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (count_down && tick && !at_floor && !(wr && hit_cnt)) |=> count_r == $past(count_r) - 16'h0001)
      else $error("down count step wrong");
   clkout_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_CLKOUT && wrap_up && !(wr && hit_cnt)) |=> count_r == $past(reload_r))
      else $error("clock-out reload missed");
   baud_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_BAUD && hi_roll && !(wr && hit_cnt)) |=> count_r == $past(reload_r))
      else $error("baud rollover reload missed");
   baud_no_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_BAUD && qual_fall && !tick && !(wr && hit_cnt)) |=> $stable(count_r))
      else $error("baud trigger edge moved the count");
   stopped_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_STOPPED && !(wr && hit_cnt)) |=> $stable(count_r))
      else $error("count moved in stopped mode");

   // count rate
   state_time_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_tick |=> (!state_tick) [*2] ##1 state_tick)
      else $error("state time not three clocks");
   tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_tick |=> (!timer_tick) [*2])
      else $error("timer ticks too close");

   // serial port ticks and clock output
   baud_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
      (hi_roll && serial_port_select != 2'h0)
      |=> events.baud_tick == (3'h1 << ($past(serial_port_select) - 2'h1)))
      else $error("baud tick on wrong port");
   baud_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !hi_roll |=> events.baud_tick == 3'h0)
      else $error("baud tick without rollover");
   divider_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(clock_out_enable && wrap_up) |=> $stable(clock_output_pin))
      else $error("clock output moved without overflow");
   shared_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_BAUD && clock_out_enable && hi_roll)
      |=> clock_output_pin != $past(clock_output_pin))
      else $error("clock output missed baud rollover");

endmodule : timer2_capture_reload_clockout

//--- tb/timer2_pins_model.sv
// timer2_pins_model: far-side pins, trigger/direction line and external count line
// assumes: driven from the bench by task calls, pins synchronous to pclk
`timescale 1ns/1ps

module timer2_pins_model
   import timer2_pkg::*;
(
   input  wire logic  pclk,
   output t2_pins_in_t pins_in
);
   // ============================================================
   // both lines idle high between edges
   initial pins_in = '{ext_trigger_pin: 1'b1, count_pin: 1'b1};

   // one falling edge held low for a chosen number of cycles, then high again
   task automatic fall_edge(input int low_cycles = 2);
      @(posedge pclk);
      pins_in.ext_trigger_pin <= 1'b0;
      repeat (low_cycles) @(posedge pclk);
      pins_in.ext_trigger_pin <= 1'b1;
   endtask : fall_edge

   // direction level for up/down counting
   task automatic set_dir(input logic up);
      @(posedge pclk);
      pins_in.ext_trigger_pin <= up;
   endtask : set_dir

   // falling edges on the external count line, one cycle low each
   task automatic count_pulses(input int n);
      repeat (n) begin
         @(posedge pclk);
         pins_in.count_pin <= 1'b0;
         @(posedge pclk);
         pins_in.count_pin <= 1'b1;
      end
   endtask : count_pulses
endmodule : timer2_pins_model

//--- tb/timer2_capture_reload_clockout_test.sv
// timer2_capture_reload_clockout_test: self-checking bench over APB with pin model
// assumes: timer2_pkg, timer2_cfg.svh and the pins model compiled first
`timescale 1ns/1ps
`include "timer2_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module timer2_capture_reload_clockout_test
   import timer2_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        err_seen;
   logic        clock_output_pin;
   logic        clock_output_oe;
   t2_pins_in_t pins_in;
   t2_events_t  events;
   logic [31:0] q;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          n;
   // baud table: port select, prescale, reload, expected tick period in pclk
   localparam logic [1:0]  bssi [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
   localparam logic [1:0]  bpre [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   localparam logic [15:0] brl  [5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFE8};
   localparam int          bper [5] = '{3, 6, 9, 12, 72};

   always #2.5 pclk = ~pclk;

   timer2_capture_reload_clockout dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
      .clock_output_pin(clock_output_pin), .clock_output_oe(clock_output_oe),
      .events(events));
   timer2_pins_model pins (.pclk(pclk), .pins_in(pins_in));

   // ============================================================
   // closing report and hang guard
   task automatic results();
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   // ============================================================
   // apb transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      q        = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, q)
   endtask : rd

   // cycles between two changes of the clock output pin
   task automatic pin_gap(output int g);
      logic v;
      v = clock_output_pin;
      @(posedge pclk iff clock_output_pin !== v);
      v = clock_output_pin;
      g = 0;
      do begin
         @(posedge pclk);
         g++;
      end while (clock_output_pin === v && g < 200);
   endtask : pin_gap

   // ============================================================
   // test sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`T2_OFF_MODE, 32'h0, "mode reset");
      rd(`T2_OFF_STATUS, 32'h0, "default mode");
      rd(12'h020, 32'h0, "unmapped data");
      `CHK("unmapped error", 1'b1, err_seen)
      // auto-reload upward, then freeze
      wr(`T2_OFF_RELOAD, 32'hFFF0);
      wr(`T2_OFF_COUNT, 32'hFFFD);
      wr(`T2_OFF_CONTROL, 32'h04);
      @(posedge pclk iff events.overflow_flag === 1'b1);
      rd(`T2_OFF_CONTROL, 32'h84, "reload flag");
      wr(`T2_OFF_CONTROL, 32'h00);
      apb(1'b0, `T2_OFF_COUNT, 32'h0);
      `CHK("reloaded count", 12'hFFF, q[15:4])
      repeat (20) @(posedge pclk);
      rd(`T2_OFF_COUNT, q, "frozen count");
      // trigger reload, then capture
      wr(`T2_OFF_RELOAD, 32'hABCD);
      wr(`T2_OFF_CONTROL, 32'h0E);
      pins.fall_edge();
      rd(`T2_OFF_COUNT, 32'hABCD, "trigger reload");
      rd(`T2_OFF_CONTROL, 32'h4E, "reload event");
      pins.count_pulses(3);
      rd(`T2_OFF_COUNT, 32'hABD0, "pin count");
      wr(`T2_OFF_COUNT, 32'h1234);
      wr(`T2_OFF_CONTROL, 32'h09);
      pins.fall_edge(5);
      rd(`T2_OFF_RELOAD, 32'h1234, "captured");
      `CHK("event out", 1'b1, events.ext_event_flag)
      rd(`T2_OFF_STATUS, 32'h2, "capture mode");
      wr(`T2_OFF_COUNT, 32'hFFFE);
      wr(`T2_OFF_CONTROL, 32'h0D);
      @(posedge pclk iff events.overflow_flag === 1'b1);
      rd(`T2_OFF_CONTROL, 32'h8D, "capture wrap");
      // up/down counting, down first then up
      wr(`T2_OFF_CONTROL, 32'h00);
      wr(`T2_OFF_MODE, 32'h01);
      wr(`T2_OFF_RELOAD, 32'h0010);
      for (int d = 0; d < 2; d++) begin
         pins.set_dir(d[0]);
         wr(`T2_OFF_COUNT, d ? 32'hFFFE : 32'h0012);
         wr(`T2_OFF_CONTROL, 32'h04);
         @(posedge pclk iff events.overflow_flag === 1'b1);
         rd(`T2_OFF_CONTROL, 32'hC4, "wrap flags");
         `CHK("event masked", 1'b0, events.ext_event_flag)
         wr(`T2_OFF_CONTROL, 32'h00);
         apb(1'b0, `T2_OFF_COUNT, 32'h0);
         `CHK("count high", d ? 8'h00 : 8'hFF, q[15:8])
      end
      wr(`T2_OFF_CONTROL, 32'h08);
      pins.fall_edge();
      rd(`T2_OFF_CONTROL, 32'h08, "updown no event");
      // baud generator over every port select and prescale
      for (int i = 0; i < 5; i++) begin
         wr(`T2_OFF_CONTROL, 32'h00);
         wr(`T2_OFF_MODE, {28'h0, bpre[i], 2'h0});
         wr(`T2_OFF_RELOAD, {16'h0, brl[i]});
         wr(`T2_OFF_COUNT, {16'h0, brl[i]});
         wr(`T2_OFF_CONTROL, {26'h0, bssi[i], 4'h4});
         @(posedge pclk iff events.baud_tick[bssi[i] - 1] === 1'b1);
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (events.baud_tick[bssi[i] - 1] !== 1'b1 && n < 200);
         `CHK("baud period", bper[i], n)
      end
      rd(`T2_OFF_STATUS, 32'h4, "baud mode");
      `CHK("baud no flag", 1'b0, events.overflow_flag)
      wr(`T2_OFF_CONTROL, 32'h18);
      wr(`T2_OFF_COUNT, 32'h1234);
      pins.fall_edge();
      rd(`T2_OFF_COUNT, 32'h1234, "no baud reload");
      rd(`T2_OFF_CONTROL, 32'h58, "baud event");
      // clock-out, prescale 1, overflow every tick
      wr(`T2_OFF_CONTROL, 32'h00);
      wr(`T2_OFF_MODE, 32'h06);
      wr(`T2_OFF_RELOAD, 32'hFFFF);
      wr(`T2_OFF_COUNT, 32'hFFFF);
      wr(`T2_OFF_CONTROL, 32'h04);
      `CHK("clock oe", 1'b1, clock_output_oe)
      rd(`T2_OFF_STATUS, 32'h1, "clock-out mode");
      for (int k = 0; k < 2; k++) begin
         pin_gap(n);
         `CHK("half period", 6, n)
      end
      `CHK("clock-out no flag", 1'b0, events.overflow_flag)
      wr(`T2_OFF_CONTROL, 32'h00);
      wr(`T2_OFF_CONTROL, 32'h14);
      pin_gap(n);
      `CHK("shared rate", 6, n)
      wr(`T2_OFF_CONTROL, 32'h05);
      rd(`T2_OFF_STATUS, 32'h3, "stopped mode");
      apb(1'b0, `T2_OFF_COUNT, 32'h0);
      repeat (12) @(posedge pclk);
      rd(`T2_OFF_COUNT, q, "stopped count");
      results();
   end
endmodule : timer2_capture_reload_clockout_test
